//--- hw/eem_host.sv
// Two-wire host controller that drives a small serial EEPROM.
`timescale 1ns/10ps
`include "eem_cfg.svh"

// Contract
// - Data line changes only while clock is low; else start or stop.
// - Every command opens with data falling while clock is high.
// - Data rising while clock high is a stop; ends reads into standby.
// - Recovery is start, nine clocks, start, then stop.
// - Device word is 1010, three select bits, then read/write bit.
// - Byte write is device word, word address, one data byte, stop.
// - Page write sends further data bytes before the final stop.
// - Host polls with start and device word until acknowledged.
// - Current read: ack address, byte out, host no-ack then stop.
// - Random read: write device word and address, repeated start, read.
// - Host ack fetches next byte; no-ack then stop ends reading.
module eem_host
    import eem_pkg::*;
#(
    parameter int unsigned WR_TIMEOUT_CYC = `EEM_WR_TIMEOUT_CYC,
    parameter int unsigned BUF_DEPTH      = `EEM_PAGE_BYTES
)
(
    input  wire logic       sys_clk,
    input  wire logic       reset,
    input  wire logic       cmd_valid,
    output logic            cmd_ready,
    input  wire eem_op_t    cmd_op,
    input  wire logic [2:0] cmd_sel,
    input  wire logic [7:0] cmd_addr,
    input  wire logic [7:0] cmd_count,
    input  wire logic       wp_req,
    input  wire logic       wr_valid,
    output logic            wr_ready,
    input  wire logic [7:0] wr_data,
    output logic            rd_valid,
    output logic      [7:0] rd_data,
    output logic            done,
    output logic            fail,
    output logic            scl,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe,
    output logic            write_protect
);

    localparam int unsigned QTR_CYC =
        (`EEM_SCL_PERIOD_NS + 4 * `EEM_CLK_PERIOD_NS - 1)
        / (4 * `EEM_CLK_PERIOD_NS);
    localparam int unsigned QW = $clog2(QTR_CYC + 1);
    localparam int unsigned TW = $clog2(WR_TIMEOUT_CYC + 1);
    localparam int unsigned BW = $clog2(BUF_DEPTH);

    eem_state_t            state;
    eem_kind_t             kind;
    eem_op_t               op;
    logic [2:0]            sel;
    logic [7:0]            addr;
    logic [7:0]            count;
    logic [7:0]            idx;
    logic [7:0]            tx_byte;
    logic [7:0]            rx_byte;
    logic [BW-1:0]         nidx;
    logic [BW-1:0]         wptr;
    logic [7:0]            buf_rdata;
    logic [QW-1:0]         qcnt;
    logic [1:0]            q;
    logic [3:0]            bitn;
    logic [TW-1:0]         tmo;
    logic [3:0]            scl_rises;
    logic                  sda_meta;
    logic                  sda_sync;
    logic                  sda_low;
    logic                  ack_seen;
    logic                  polling;
    logic                  poll_ok;
    logic                  err;
    logic                  tick;
    logic                  end_q;
    logic                  byte_end;
    logic                  last_byte;
    logic                  tmo_hit;
    logic                  drive_bit;

    function automatic logic [7:0] dev_word(input logic [2:0] s,
                                            input logic       rd);
        return {`EEM_DEV_CODE, s, rd};
    endfunction : dev_word

    // ======================================================================
    // Pin synchroniser and fixed outputs
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            sda_meta <= 1'b1;
            sda_sync <= 1'b1;
        end
        else
        begin
            sda_meta <= sda_in;
            sda_sync <= sda_meta;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
            write_protect <= 1'b0;
        else
            write_protect <= wp_req;
    end

    assign sda_out   = 1'b0;
    assign sda_oe    = sda_low;
    assign cmd_ready = (state == S_IDLE);
    assign wr_ready  = (state == S_IDLE);

    // ======================================================================
    // Quarter-bit timing
    assign tick      = (qcnt == QW'(QTR_CYC - 1));
    assign end_q     = tick && (q == 2'd3);
    assign byte_end  = end_q && (state == S_XFER) && (bitn == `EEM_ACK_BIT);
    assign last_byte = (idx == count);
    assign tmo_hit   = (tmo == TW'(WR_TIMEOUT_CYC));

    always_ff @(posedge sys_clk)
    begin
        if (reset || state == S_IDLE || state == S_DONE)
        begin
            qcnt <= '0;
            q    <= 2'd0;
        end
        else if (tick)
        begin
            qcnt <= '0;
            q    <= q + 2'd1;
        end
        else
            qcnt <= qcnt + QW'(1);
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset || state != S_XFER)
            bitn <= 4'd0;
        else if (end_q)
            bitn <= (bitn == `EEM_ACK_BIT) ? 4'd0 : bitn + 4'd1;
    end

    // ======================================================================
    // Bit to drive during the low half of each clock
    always_comb
    begin
        drive_bit = 1'b0;
        if (bitn == `EEM_ACK_BIT)
            drive_bit = (kind == K_READ) && !last_byte;
        else if (kind != K_READ && kind != K_CLK9)
            drive_bit = !tx_byte[3'd7 - bitn[2:0]];
    end

    // ======================================================================
    // Clock and data line sequencing
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            scl     <= 1'b1;
            sda_low <= 1'b0;
        end
        else if (tick)
        begin
            case (state)
                S_START:
                begin
                    case (q)
                        2'd0: sda_low <= 1'b0;
                        2'd1: scl     <= 1'b1;
                        2'd2: sda_low <= 1'b1;
                        default: scl  <= 1'b0;
                    endcase
                end
                S_XFER:
                begin
                    case (q)
                        2'd0: sda_low <= drive_bit;
                        2'd1: scl     <= 1'b1;
                        2'd3: scl     <= 1'b0;
                        default: ;
                    endcase
                end
                S_STOP:
                begin
                    case (q)
                        2'd0: sda_low <= 1'b1;
                        2'd1: scl     <= 1'b1;
                        2'd2: sda_low <= 1'b0;
                        default: ;
                    endcase
                end
                default: ;
            endcase
        end
    end

    // ======================================================================
    // Receive shift and acknowledge sampling
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            rx_byte  <= '0;
            ack_seen <= 1'b0;
        end
        else if (tick && q == 2'd2 && state == S_XFER)
        begin
            if (bitn == `EEM_ACK_BIT)
                ack_seen <= !sda_sync;
            else
                rx_byte <= {rx_byte[6:0], sda_sync};
        end
    end

    // ======================================================================
    // Command sequencer
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            state   <= S_IDLE;
            kind    <= K_DEVW;
            op      <= OP_WRITE;
            sel     <= '0;
            addr    <= '0;
            count   <= '0;
            idx     <= '0;
            nidx    <= '0;
            tx_byte <= '0;
            polling <= 1'b0;
            poll_ok <= 1'b0;
            err     <= 1'b0;
        end
        else
        begin
            case (state)
                S_IDLE:
                begin
                    if (cmd_valid)
                    begin
                        op      <= cmd_op;
                        sel     <= cmd_sel;
                        addr    <= cmd_addr;
                        count   <= cmd_count;
                        idx     <= '0;
                        nidx    <= '0;
                        polling <= 1'b0;
                        poll_ok <= 1'b0;
                        err     <= 1'b0;
                        state   <= S_START;
                        if (cmd_op == OP_SOFT_RESET)
                            kind <= K_CLK9;
                        else if (cmd_op == OP_READ_CUR)
                            kind <= K_DEVR;
                        else
                            kind <= K_DEVW;
                        tx_byte <= dev_word(cmd_sel,
                                            cmd_op == OP_READ_CUR);
                    end
                end
                S_START:
                begin
                    if (end_q)
                        state <= (kind == K_SRST2) ? S_STOP : S_XFER;
                end
                S_XFER:
                begin
                    if (byte_end)
                    begin
                        case (kind)
                            K_DEVW:
                            begin
                                if (!ack_seen)
                                begin
                                    err   <= !polling;
                                    state <= S_STOP;
                                end
                                else if (polling)
                                begin
                                    poll_ok <= 1'b1;
                                    state   <= S_STOP;
                                end
                                else
                                begin
                                    kind    <= K_ADDR;
                                    tx_byte <= addr;
                                end
                            end
                            K_ADDR:
                            begin
                                if (!ack_seen)
                                begin
                                    err   <= 1'b1;
                                    state <= S_STOP;
                                end
                                else if (op == OP_READ_RAND)
                                begin
                                    kind    <= K_DEVR;
                                    tx_byte <= dev_word(sel, `EEM_RW_READ);
                                    state   <= S_START;
                                end
                                else
                                begin
                                    kind    <= K_DATA;
                                    tx_byte <= buf_rdata;
                                    nidx    <= nidx + BW'(1);
                                end
                            end
                            K_DATA:
                            begin
                                if (!ack_seen)
                                begin
                                    err   <= 1'b1;
                                    state <= S_STOP;
                                end
                                else if (last_byte)
                                    state <= S_STOP;
                                else
                                begin
                                    tx_byte <= buf_rdata;
                                    nidx    <= nidx + BW'(1);
                                    idx     <= idx + 8'd1;
                                end
                            end
                            K_DEVR:
                            begin
                                if (!ack_seen)
                                begin
                                    err   <= 1'b1;
                                    state <= S_STOP;
                                end
                                else
                                    kind <= K_READ;
                            end
                            K_READ:
                            begin
                                if (last_byte)
                                    state <= S_STOP;
                                else
                                    idx <= idx + 8'd1;
                            end
                            K_CLK9:
                            begin
                                kind  <= K_SRST2;
                                state <= S_START;
                            end
                            default: state <= S_STOP;
                        endcase
                    end
                end
                S_STOP:
                begin
                    if (end_q)
                    begin
                        if (op == OP_WRITE && !polling && !err)
                        begin
                            polling <= 1'b1;
                            state   <= S_GAP;
                        end
                        else if (polling && !poll_ok && !tmo_hit)
                            state <= S_GAP;
                        else
                        begin
                            if (polling && !poll_ok)
                                err <= 1'b1;
                            state <= S_DONE;
                        end
                    end
                end
                S_GAP:
                begin
                    if (end_q)
                    begin
                        state   <= S_START;
                        kind    <= K_DEVW;
                        tx_byte <= dev_word(sel, `EEM_RW_WRITE);
                    end
                end
                S_DONE: state <= S_IDLE;
                default: state <= S_IDLE;
            endcase
        end
    end

    // ======================================================================
    // Write-cycle timeout while polling
    always_ff @(posedge sys_clk)
    begin
        if (reset || !polling)
            tmo <= '0;
        else if (!tmo_hit)
            tmo <= tmo + TW'(1);
    end

    // ======================================================================
    // Page buffer and user data ports
    always_ff @(posedge sys_clk)
    begin
        if (reset || state == S_DONE)
            wptr <= '0;
        else if (wr_valid && wr_ready)
            wptr <= wptr + BW'(1);
    end

    eem_page_buf #(
        .WIDTH (8),
        .DEPTH (BUF_DEPTH),
        .AW    (BW)
    ) u_page_buf (
        .sys_clk (sys_clk),
        .reset   (reset),
        .wr_en   (wr_valid && wr_ready),
        .wr_addr (wptr),
        .wr_data (wr_data),
        .rd_addr (nidx),
        .rd_data (buf_rdata)
    );

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            rd_valid <= 1'b0;
            rd_data  <= '0;
        end
        else
        begin
            rd_valid <= byte_end && (kind == K_READ);
            if (byte_end && kind == K_READ)
                rd_data <= rx_byte;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            done <= 1'b0;
            fail <= 1'b0;
        end
        else
        begin
            done <= (state == S_DONE);
            if (state == S_DONE)
                fail <= err;
        end
    end

    // ======================================================================
    // Checks
    always_ff @(posedge sys_clk)
    begin
        if (reset || state != S_XFER)
            scl_rises <= 4'd0;
        else if (tick && q == 2'd1)
            scl_rises <= scl_rises + 4'd1;
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    sequence s_byte_done;
        state == S_XFER && bitn == `EEM_ACK_BIT && tick && q == 2'd3;
    endsequence

    sequence s_stop_end;
        state == S_STOP && tick && q == 2'd3;
    endsequence

    scl_high_hold_a: assert property (
        (state == S_XFER && scl && $past(scl)) |-> $stable(sda_oe))
        else $error("Data line moved while clock high.");

    start_only_a: assert property (
        ($rose(sda_oe) && scl) |-> state == S_START)
        else $error("Data fell with clock high outside a start.");

    stop_only_a: assert property (
        ($fell(sda_oe) && scl) |-> state == S_STOP)
        else $error("Data rose with clock high outside a stop.");

    msb_first_a: assert property (
        (state == S_XFER && bitn == 4'd0 && q == 2'd1
         && kind != K_READ && kind != K_CLK9) |-> sda_oe == !tx_byte[7])
        else $error("First bit sent is not the most significant.");

    dev_word_a: assert property (
        (state == S_XFER && (kind == K_DEVW || kind == K_DEVR))
        |-> tx_byte == {`EEM_DEV_CODE, sel, kind == K_DEVR})
        else $error("Device word pattern or direction wrong.");

    read_ack_a: assert property (
        (state == S_XFER && kind == K_READ && bitn == `EEM_ACK_BIT
         && q == 2'd1) |-> sda_oe == !last_byte)
        else $error("Read acknowledge level wrong.");

    soft_reset_a: assert property (
        ($past(state) == S_XFER && state != S_XFER
         && $past(kind) == K_CLK9)
        |-> scl_rises == `EEM_SRST_CLOCKS && state == S_START)
        else $error("Recovery did not give nine clocks then start.");

    rand_read_a: assert property (
        (s_byte_done ##0 (kind == K_ADDR && ack_seen
                          && op == OP_READ_RAND))
        |=> state == S_START && kind == K_DEVR ##1 !sda_oe)
        else $error("Random read missed repeated start.");

    write_stop_a: assert property (
        (s_byte_done ##0 (kind == K_DATA && ack_seen && last_byte))
        |=> state == S_STOP)
        else $error("Last write byte not followed by a stop.");

    poll_start_a: assert property (
        (s_stop_end ##0 (op == OP_WRITE && !polling && !err))
        |=> state == S_GAP && polling)
        else $error("Write stop not followed by polling.");

endmodule : eem_host

//--- hw/eem_cfg.svh
// Timing, address and sizing constants for the EEPROM host controller.
`ifndef EEM_CFG_SVH
`define EEM_CFG_SVH

// ==========================================================================
// Clocking
`define EEM_CLK_PERIOD_NS 4
`define EEM_SCL_PERIOD_NS 2500
`define EEM_WR_CYCLE_MS   5
`define EEM_WR_TIMEOUT_CYC ((`EEM_WR_CYCLE_MS * 1000000) / `EEM_CLK_PERIOD_NS)

// ==========================================================================
// Address word layout
`define EEM_DEV_CODE      4'ha
`define EEM_RW_READ       1'b1
`define EEM_RW_WRITE      1'b0
`define EEM_WORD_ADDR_W   8
`define EEM_PAGE_BYTES    8
`define EEM_PAGE_IDX_W    3
`define EEM_ACK_BIT       4'd8
`define EEM_SRST_CLOCKS   4'd9

`endif

//--- hw/eem_pkg.sv
// Types shared by the EEPROM host controller.
package eem_pkg;

    // ======================================================================
    // Sequencer states, byte kinds and user commands
    typedef enum logic [2:0] {
        S_IDLE, S_START, S_XFER, S_STOP, S_GAP, S_DONE
    } eem_state_t;

    typedef enum logic [2:0] {
        K_DEVW, K_ADDR, K_DATA, K_DEVR, K_READ, K_CLK9, K_SRST2
    } eem_kind_t;

    typedef enum logic [1:0] {
        OP_WRITE, OP_READ_CUR, OP_READ_RAND, OP_SOFT_RESET
    } eem_op_t;

endpackage : eem_pkg

//--- hw/eem_page_buf.sv
// Small page buffer holding the bytes of one write command.
`timescale 1ns/10ps
module eem_page_buf
#(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 8,
    parameter int unsigned AW    = $clog2(DEPTH)
)
(
    input  wire logic             sys_clk,
    input  wire logic             reset,
    input  wire logic             wr_en,
    input  wire logic [AW-1:0]    wr_addr,
    input  wire logic [WIDTH-1:0] wr_data,
    input  wire logic [AW-1:0]    rd_addr,
    output logic      [WIDTH-1:0] rd_data
);

    logic [WIDTH-1:0] mem [DEPTH];

    // ======================================================================
    // Storage and registered read port
    always_ff @(posedge sys_clk)
    begin
        if (wr_en)
            mem[wr_addr] <= wr_data;
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
            rd_data <= '0;
        else
            rd_data <= mem[rd_addr];
    end

endmodule : eem_page_buf

//--- verif/eem_dev_model.sv
// Behavioural serial EEPROM that answers the host controller.
`timescale 1ns/10ps
module eem_dev_model
#(
    parameter logic [2:0] SEL    = 3'h5,
    parameter int         TWR_NS = 4000
)
(
    input  wire logic scl,
    input  wire logic sda,
    input  wire logic wp,
    output logic      pull
);
    // ======================================================================
    // Array, bit counter and byte decoding
    logic [7:0] mem [256];
    logic [7:0] ptr, sh, ob;
    logic       act, rd, busy, dirty;
    int         n, nb;
    initial
    begin
        for (int i = 0; i < 256; i++)
            mem[i] = i[7:0] ^ 8'h5a;
        {pull, act, rd, busy, dirty, ptr, n, nb} = '0;
    end
    always @(negedge sda)
        if (scl)
        begin
            n = 0;
            nb = 0;
            rd = 1'b0;
            act = !busy;
        end
    always @(posedge sda)
        if (scl)
        begin
            act = 1'b0;
            if (dirty)
            begin
                busy <= 1'b1;
                busy <= #TWR_NS 1'b0;
            end
            dirty = 1'b0;
        end
    always @(posedge scl)
        if (act)
        begin
            if (n < 8)
                sh = {sh[6:0], sda};
            else if (rd && nb > 1 && sda)
                act = 1'b0;
            n = n + 1;
        end
    always @(negedge scl)
        if (act)
        begin
            if (n == 8 && rd && nb > 0)
                pull = 1'b0;
            else if (n == 8 && nb == 0)
            begin
                rd = sh[0];
                act = (sh[7:1] == {4'ha, SEL});
                pull = act;
            end
            else if (n == 8)
            begin
                if (nb == 1)
                    ptr = sh;
                else
                begin
                    if (!wp)
                    begin
                        mem[ptr] = sh;
                        dirty = 1'b1;
                    end
                    ptr = {ptr[7:3], ptr[2:0] + 3'h1};
                end
                pull = 1'b1;
            end
            if (n == 8)
                nb = nb + 1;
            if (n == 9)
            begin
                n = 0;
                pull = 1'b0;
                if (rd)
                begin
                    ob = mem[ptr];
                    ptr = ptr + 8'h01;
                    pull = !ob[7];
                end
            end
            else if (n < 8 && rd && nb > 0)
                pull = !ob[7 - n];
        end
endmodule : eem_dev_model

//--- verif/eem_host_tb.sv
// Self-checking bench for the EEPROM host controller.
`timescale 1ns/10ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_total++; \
    $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module eem_host_tb
    import eem_pkg::*;
;
    // ======================================================================
    // Stimulus, device model and scenarios
    logic       sys_clk = 1'b0, reset = 1'b1, cmd_valid = 1'b0;
    logic       wp_req = 1'b0, wr_valid = 1'b0;
    eem_op_t    cmd_op = OP_WRITE;
    logic [2:0] cmd_sel = 3'h5;
    logic [7:0] cmd_addr = 8'h00, cmd_count = 8'h00, wr_data = 8'h00;
    logic       cmd_ready, wr_ready, rd_valid, done, fail, scl;
    logic       sda_out, sda_oe, write_protect, pull;
    logic [7:0] rd_data;
    logic [7:0] q [$];
    int         err_total = 0, checks = 0;
    wire        sda = !(sda_oe || pull);
    always #2 sys_clk = !sys_clk;
    eem_host #(.WR_TIMEOUT_CYC(20000)) eem_host_inst (.sys_clk(sys_clk),
        .reset(reset), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd_op(cmd_op), .cmd_sel(cmd_sel), .cmd_addr(cmd_addr),
        .cmd_count(cmd_count), .wp_req(wp_req), .wr_valid(wr_valid),
        .wr_ready(wr_ready), .wr_data(wr_data), .rd_valid(rd_valid),
        .rd_data(rd_data), .done(done), .fail(fail), .scl(scl),
        .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
        .write_protect(write_protect));
    eem_dev_model eem_dev_model_inst (.scl(scl), .sda(sda),
        .wp(write_protect), .pull(pull));
    task automatic load(logic [7:0] b);
        wr_valid = 1'b1;
        wr_data = b;
        @(negedge sys_clk);
    endtask : load
    task automatic run(eem_op_t op, logic [2:0] sel, logic [7:0] adr,
                       logic [7:0] cnt);
        wr_valid = 1'b0;
        cmd_op = op;
        cmd_sel = sel;
        cmd_addr = adr;
        cmd_count = cnt;
        cmd_valid = 1'b1;
        @(negedge sys_clk);
        cmd_valid = 1'b0;
        `CHK(cmd_ready, 1'b0)
        q.delete();
        for (int i = 0; i < 60000 && done !== 1'b1; i++)
        begin
            @(negedge sys_clk);
            if (rd_valid === 1'b1)
                q.push_back(rd_data);
        end
        `CHK(done, 1'b1)
        `CHK(wr_ready, 1'b1)
    endtask : run
    task automatic t_page_wrap;
        load(8'hc3);
        load(8'h3c);
        run(OP_WRITE, 3'h5, 8'hff, 8'h01);
        `CHK(fail, 1'b0)
        `CHK(eem_dev_model_inst.mem[8'hff], 8'hc3)
        `CHK(eem_dev_model_inst.mem[8'hf8], 8'h3c)
        `CHK(eem_dev_model_inst.mem[8'h00], 8'h5a)
    endtask : t_page_wrap
    task automatic t_read_wrap;
        run(OP_READ_RAND, 3'h5, 8'hff, 8'h01);
        `CHK(q.size(), 2)
        `CHK(q[0], 8'hc3)
        `CHK(q[1], 8'h5a)
    endtask : t_read_wrap
    task automatic t_protect;
        wp_req = 1'b1;
        load(8'h77);
        run(OP_WRITE, 3'h5, 8'h10, 8'h00);
        `CHK(write_protect, 1'b1)
        `CHK(fail, 1'b0)
        `CHK(eem_dev_model_inst.mem[8'h10], 8'h4a)
        wp_req = 1'b0;
    endtask : t_protect
    task automatic t_sel_miss;
        run(OP_READ_CUR, 3'h2, 8'h00, 8'h00);
        `CHK(fail, 1'b1)
        `CHK(q.size(), 0)
    endtask : t_sel_miss
    task automatic t_soft_reset;
        run(OP_SOFT_RESET, 3'h5, 8'h00, 8'h00);
        `CHK(fail, 1'b0)
        `CHK({scl, sda}, 2'b11)
        `CHK(sda_out, 1'b0)
    endtask : t_soft_reset
    task automatic print_verdict;
        $display("checks=%0d err_total=%0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : print_verdict
    initial
    begin
        repeat (20) @(negedge sys_clk);
        reset = 1'b0;
        t_page_wrap();
        t_read_wrap();
        t_protect();
        t_sel_miss();
        t_soft_reset();
        print_verdict();
    end
    initial
    begin
        #450000;
        err_total++;
        print_verdict();
    end
endmodule : eem_host_tb
